// >>> hw/dmc_exec.sv
// decode and execution of the compute plus dual memory move instruction
// assumes the register file, compute units and both memories sit outside
// and act on the registered requests issued two cycles after the word
//
// Notes on behaviour
// RULE1 - each instruction carries one compute plus memory transfers, all in parallel.
// RULE2 - compute goes to exactly one unit: alu, multiplier or shifter.
// RULE3 - multiplier-result moves count as multiplier computations, not memory moves.
// RULE4 - single-element mode does one data and one program access from index registers.
// RULE5 - index plus modify is written back; the unmodified index is the address.
// RULE6 - no pre-modify form; address never includes the modify value.
// RULE7 - dual-element mode repeats compute and both transfers in the second element.
// RULE8 - dual mode: first element uses index, second element uses index plus one.
// RULE9 - broadcast on index one or nine: second element uses the unincremented index.
// RULE10 - broadcast read loads one memory value into both elements' registers.
// RULE11 - second element transfers through the complementary register of each named one.
// RULE12 - second element uses index plus one, zero offset; only first element updates.
// RULE13 - data transfer uses first address generator, program transfer the second.
// RULE14 - the two transfer directions are chosen independently.
// RULE15 - one direction bit per transfer selects memory read or memory write.
// RULE16 - an empty compute field makes the compute part a no-operation.
// RULE17 - type recognised from top three opcode bits; fields as laid out in the package.
// RULE18 - index write-back is seen by the very next instruction without a stall.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.

`timescale 1ns/1ps

module dmc_exec
  import dmc_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int AXI_AW = 8
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [AXI_AW-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                instr_valid,
  input  wire logic [INSTR_W-1:0]  instr_word,
  output logic                     ex_valid,
  output logic                     ex_dual,
  output logic                     ex_alu_go,
  output logic                     ex_mul_go,
  output logic                     ex_shf_go,
  output logic [COMP_W-1:0]        ex_compute,
  output logic                     dm_write,
  output logic [DATA_W-1:0]        dm_addr_x,
  output logic [DATA_W-1:0]        dm_addr_y,
  output logic [3:0]               dm_dreg,
  output logic                     dm_shared,
  output logic                     pm_write,
  output logic [DATA_W-1:0]        pm_addr_x,
  output logic [DATA_W-1:0]        pm_addr_y,
  output logic [3:0]               pm_dreg,
  output logic                     pm_shared
);

  if (DATA_W != 32 || AXI_AW < 8) begin : g_chk
    $error("dmc_exec: data must be 32 bits and the address at least 8 bits");
  end

  // ****************************************************************
  // register slave
  // ****************************************************************
  logic [2:0]        mode_reg;
  logic [31:0]       exec_cnt_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rd_pend_reg;
  logic [AXI_AW-1:0] rd_addr_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic              wr_fire;
  logic              ar_fire;
  logic              wr_bank;
  logic              wr_hit;
  logic [4:0]        bus_bank_idx;
  logic [DATA_W-1:0] bus_rd_data;

  assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_arready = !rd_pend_reg && !rvalid_reg;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // bank words only take whole-word writes, a read-modify-write would cost a port
  assign wr_bank = (s_axi_awaddr[7:6] == WIN_IDX || s_axi_awaddr[7:6] == WIN_MOD)
                   && s_axi_wstrb == 4'hF;
  assign wr_hit  = wr_bank || s_axi_awaddr[7:0] == OFS_MODE;
  assign bus_bank_idx = {s_axi_awaddr[7], s_axi_awaddr[5:2]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= MODE_RESET;
    end else if (wr_fire && s_axi_awaddr[7:0] == OFS_MODE && s_axi_wstrb[0]) begin
      mode_reg <= s_axi_wdata[2:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // bank read data arrive one cycle after the address, so the answer takes two
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= '0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= RESP_OKAY;
    end else begin
      rd_pend_reg <= ar_fire;
      if (ar_fire) begin
        rd_addr_reg <= s_axi_araddr;
      end
      if (rd_pend_reg) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= RESP_OKAY;
        if (rd_addr_reg[7:6] == WIN_IDX || rd_addr_reg[7:6] == WIN_MOD) begin
          rdata_reg <= bus_rd_data;
        end else if (rd_addr_reg[7:0] == OFS_MODE) begin
          rdata_reg <= {29'h0, mode_reg};
        end else if (rd_addr_reg[7:0] == OFS_EXEC_CNT) begin
          rdata_reg <= exec_cnt_reg;
        end else begin
          rdata_reg <= 32'h0;
          rresp_reg <= RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // issue: decode and capture fields, launch bank reads
  // ****************************************************************
  logic              is_type;
  logic              s1_valid_reg;
  logic              s1_dm_dir_reg;
  logic              s1_pm_dir_reg;
  logic [2:0]        s1_dm_idx_reg;
  logic [2:0]        s1_pm_idx_reg;
  logic [3:0]        s1_dm_dreg_reg;
  logic [3:0]        s1_pm_dreg_reg;
  logic [COMP_W-1:0] s1_comp_reg;
  logic [2:0]        s1_mode_reg;

  assign is_type = instr_valid && instr_word[TYPE_HI:TYPE_LO] == TYPE_CODE;  // [RULE17]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_valid_reg <= 1'b0;
    end else begin
      s1_valid_reg <= is_type;  // [RULE1]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_dm_dir_reg  <= 1'b0;
      s1_pm_dir_reg  <= 1'b0;
      s1_dm_idx_reg  <= 3'h0;
      s1_pm_idx_reg  <= 3'h0;
      s1_dm_dreg_reg <= 4'h0;
      s1_pm_dreg_reg <= 4'h0;
      s1_comp_reg    <= '0;
      s1_mode_reg    <= MODE_RESET;
    end else if (is_type) begin
      s1_dm_dir_reg  <= instr_word[DM_DIR_POS];  // [RULE15]
      s1_pm_dir_reg  <= instr_word[PM_DIR_POS];  // [RULE14]
      s1_dm_idx_reg  <= instr_word[DM_IDX_LO +: 3];
      s1_pm_idx_reg  <= instr_word[PM_IDX_LO +: 3];
      s1_dm_dreg_reg <= instr_word[DM_DREG_LO +: 4];
      s1_pm_dreg_reg <= instr_word[PM_DREG_LO +: 4];
      s1_comp_reg    <= instr_word[COMP_W-1:0];
      s1_mode_reg    <= mode_reg;
    end
  end

  // ****************************************************************
  // address generation and post-modify write-back
  // ****************************************************************
  logic [5*5-1:0]      rd_addr_vec;
  logic [5*DATA_W-1:0] rd_data_vec;
  logic [2:0]          wr_en_vec;
  logic [3*5-1:0]      wr_addr_vec;
  logic [3*DATA_W-1:0] wr_data_vec;
  logic [DATA_W-1:0]   dm_i_eff;
  logic [DATA_W-1:0]   pm_i_eff;
  logic [DATA_W-1:0]   dm_m_val;
  logic [DATA_W-1:0]   pm_m_val;
  logic                wb1_valid_reg;
  logic [2:0]          wb1_idx_reg;
  logic [DATA_W-1:0]   wb1_val_reg;
  logic                wb2_valid_reg;
  logic [2:0]          wb2_idx_reg;
  logic [DATA_W-1:0]   wb2_val_reg;
  logic                dm_bcast;
  logic                pm_bcast;
  logic [1:0]          unit_sel;

  function automatic logic [4:0] bus_bank_idx_rd(input logic [AXI_AW-1:0] a);
    bus_bank_idx_rd = {a[7], a[5:2]};
  endfunction

  // data side reads the first generator's bank half, program side the second
  assign rd_addr_vec = {bus_bank_idx_rd(s_axi_araddr),
                        BANK_GEN2_MOD, instr_word[PM_MOD_LO +: 3],
                        BANK_GEN1_MOD, instr_word[DM_MOD_LO +: 3],
                        BANK_GEN2_IDX, instr_word[PM_IDX_LO +: 3],
                        BANK_GEN1_IDX, instr_word[DM_IDX_LO +: 3]};  // [RULE13]
  assign dm_m_val    = rd_data_vec[2*DATA_W +: DATA_W];
  assign pm_m_val    = rd_data_vec[3*DATA_W +: DATA_W];
  assign bus_rd_data = rd_data_vec[4*DATA_W +: DATA_W];

  // a write-back from the previous instruction landed on the same edge as the
  // bank read, so the bank still shows the old index: forward it
  assign dm_i_eff = (wb1_valid_reg && wb1_idx_reg == s1_dm_idx_reg) ? wb1_val_reg
                    : rd_data_vec[0 +: DATA_W];  // [RULE18]
  assign pm_i_eff = (wb2_valid_reg && wb2_idx_reg == s1_pm_idx_reg) ? wb2_val_reg
                    : rd_data_vec[DATA_W +: DATA_W];  // [RULE18]

  assign dm_bcast = s1_mode_reg[MODE_BC_ONE] && s1_dm_idx_reg == BCAST_SLOT;   // [RULE9]
  assign pm_bcast = s1_mode_reg[MODE_BC_NINE] && s1_pm_idx_reg == BCAST_SLOT;  // [RULE9]

  // instruction write-back sits on the high-priority ports; a bus write to the
  // same index in that cycle is lost
  assign wr_en_vec   = {wr_fire && wr_bank, s1_valid_reg, s1_valid_reg};
  assign wr_addr_vec = {bus_bank_idx, BANK_GEN2_IDX, s1_pm_idx_reg, BANK_GEN1_IDX, s1_dm_idx_reg};
  assign wr_data_vec = {s_axi_wdata, DATA_W'(pm_i_eff + pm_m_val), DATA_W'(dm_i_eff + dm_m_val)};  // [RULE5]

  dmc_idx_bank #(
    .DATA_W (DATA_W),
    .ADDR_W (5),
    .N_RD   (5),
    .N_WR   (3)
  ) u_bank (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rd_addr (rd_addr_vec),
    .rd_data (rd_data_vec),
    .wr_en   (wr_en_vec),
    .wr_addr (wr_addr_vec),
    .wr_data (wr_data_vec)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wb1_valid_reg <= 1'b0;
      wb1_idx_reg   <= 3'h0;
      wb1_val_reg   <= '0;
      wb2_valid_reg <= 1'b0;
      wb2_idx_reg   <= 3'h0;
      wb2_val_reg   <= '0;
    end else begin
      wb1_valid_reg <= s1_valid_reg;
      wb1_idx_reg   <= s1_dm_idx_reg;
      wb1_val_reg   <= DATA_W'(dm_i_eff + dm_m_val);  // [RULE12]
      wb2_valid_reg <= s1_valid_reg;
      wb2_idx_reg   <= s1_pm_idx_reg;
      wb2_val_reg   <= DATA_W'(pm_i_eff + pm_m_val);
    end
  end

  // ****************************************************************
  // execute outputs
  // ****************************************************************
  logic [2:0]        ex_dm_idx_reg;
  logic [DATA_W-1:0] ex_dm_mod_reg;

  assign unit_sel = s1_comp_reg[UNIT_LO +: 2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ex_valid      <= 1'b0;
      ex_dual       <= 1'b0;
      ex_alu_go     <= 1'b0;
      ex_mul_go     <= 1'b0;
      ex_shf_go     <= 1'b0;
      ex_compute    <= '0;
      dm_write      <= 1'b0;
      dm_addr_x     <= '0;
      dm_addr_y     <= '0;
      dm_dreg       <= 4'h0;
      dm_shared     <= 1'b0;
      pm_write      <= 1'b0;
      pm_addr_x     <= '0;
      pm_addr_y     <= '0;
      pm_dreg       <= 4'h0;
      pm_shared     <= 1'b0;
      ex_dm_idx_reg <= 3'h0;
      ex_dm_mod_reg <= '0;
    end else begin
      ex_valid      <= s1_valid_reg;
      ex_dual       <= s1_valid_reg && s1_mode_reg[MODE_DUAL];  // [RULE7]
      // an empty compute field sends nothing to any unit
      ex_alu_go     <= s1_valid_reg && s1_comp_reg != '0 && unit_sel == UNIT_ALU;  // [RULE2] [RULE16]
      ex_mul_go     <= s1_valid_reg && s1_comp_reg != '0
                       && (unit_sel == UNIT_MUL || unit_sel == UNIT_RES_MOVE);  // [RULE3]
      ex_shf_go     <= s1_valid_reg && s1_comp_reg != '0 && unit_sel == UNIT_SHF;  // [RULE2]
      ex_compute    <= s1_comp_reg;
      dm_write      <= s1_dm_dir_reg;  // [RULE15]
      pm_write      <= s1_pm_dir_reg;  // [RULE14]
      dm_addr_x     <= dm_i_eff;  // [RULE4] [RULE6]
      pm_addr_x     <= pm_i_eff;  // [RULE4] [RULE6]
      dm_addr_y     <= (s1_mode_reg[MODE_DUAL] && !dm_bcast) ? DATA_W'(dm_i_eff + 1'b1) : dm_i_eff;  // [RULE8]
      pm_addr_y     <= (s1_mode_reg[MODE_DUAL] && !pm_bcast) ? DATA_W'(pm_i_eff + 1'b1) : pm_i_eff;  // [RULE8]
      dm_dreg       <= s1_dm_dreg_reg;  // [RULE11]
      pm_dreg       <= s1_pm_dreg_reg;  // [RULE11]
      dm_shared     <= s1_mode_reg[MODE_DUAL] && dm_bcast;  // [RULE10]
      pm_shared     <= s1_mode_reg[MODE_DUAL] && pm_bcast;
      ex_dm_idx_reg <= s1_dm_idx_reg;
      ex_dm_mod_reg <= dm_m_val;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exec_cnt_reg <= 32'h0;
    end else if (ex_valid) begin
      exec_cnt_reg <= exec_cnt_reg + 32'h1;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_type_issue: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE17]
    is_type |-> ##2 ex_valid)
    else $error("recognised instruction did not execute two cycles later");

  a_other_ignored: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE1]
    !is_type |-> ##2 !ex_valid)
    else $error("unrecognised word produced an execution");

  a_one_unit: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE2]
    ex_valid && ex_compute != '0 |-> $onehot({ex_alu_go, ex_mul_go, ex_shf_go}))
    else $error("compute not sent to exactly one unit");

  a_nop_idle: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE16]
    ex_valid && ex_compute == '0 |-> !(ex_alu_go || ex_mul_go || ex_shf_go))
    else $error("empty compute field started a unit");

  a_dir_pass: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE15]
    is_type |-> ##2 (dm_write == $past(instr_word[DM_DIR_POS], 2)
                    && pm_write == $past(instr_word[PM_DIR_POS], 2)))
    else $error("transfer direction differs from the instruction");

  a_dreg_pass: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE11]
    is_type |-> ##2 (dm_dreg == $past(instr_word[DM_DREG_LO +: 4], 2)
                    && pm_dreg == $past(instr_word[PM_DREG_LO +: 4], 2)))
    else $error("register selects differ from the instruction");

  a_y_addr_inc: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE8]
    ex_valid && ex_dual && !dm_shared |-> dm_addr_y == DATA_W'(dm_addr_x + 1'b1))
    else $error("second element data address is not index plus one");

  a_bcast_same: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE9]
    ex_valid && (dm_shared || !ex_dual) |-> dm_addr_y == dm_addr_x)
    else $error("shared access uses different addresses");

  a_post_modify: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE5]
    ex_valid && $past(ex_valid) && ex_dm_idx_reg == $past(ex_dm_idx_reg) && !$past(wr_fire, 2)
    |-> dm_addr_x == DATA_W'($past(dm_addr_x) + $past(ex_dm_mod_reg)))
    else $error("back-to-back index use did not see the post-modified value");

  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");

endmodule

// >>> hw/dmc_pkg.sv
// constants shared by the dual-move compute decoder and its index bank
// assumes a 48-bit instruction word and a 32-bit AXI4-Lite register slave

package dmc_pkg;

  // ****************************************************************
  // instruction word layout
  // ****************************************************************
  localparam int          INSTR_W       = 48;
  localparam int          TYPE_HI       = 47;
  localparam int          TYPE_LO       = 45;
  localparam logic [2:0]  TYPE_CODE     = 3'h1;
  localparam int          DM_DIR_POS    = 44;
  localparam int          DM_IDX_LO     = 41;
  localparam int          DM_MOD_LO     = 38;
  localparam int          PM_DIR_POS    = 37;
  localparam int          DM_DREG_LO    = 33;
  localparam int          PM_IDX_LO     = 30;
  localparam int          PM_MOD_LO     = 27;
  localparam int          PM_DREG_LO    = 23;
  localparam int          COMP_W        = 23;
  localparam int          UNIT_LO       = 20;

  // compute unit selector inside the compute field
  localparam logic [1:0]  UNIT_ALU      = 2'h0;
  localparam logic [1:0]  UNIT_MUL      = 2'h1;
  localparam logic [1:0]  UNIT_SHF      = 2'h2;
  localparam logic [1:0]  UNIT_RES_MOVE = 2'h3;

  // ****************************************************************
  // index bank layout: I0-I7, I8-I15, M0-M7, M8-M15
  // ****************************************************************
  localparam logic [1:0]  BANK_GEN1_IDX = 2'h0;
  localparam logic [1:0]  BANK_GEN2_IDX = 2'h1;
  localparam logic [1:0]  BANK_GEN1_MOD = 2'h2;
  localparam logic [1:0]  BANK_GEN2_MOD = 2'h3;
  localparam logic [2:0]  BCAST_SLOT    = 3'h1;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0]  OFS_MODE      = 8'h00;
  localparam logic [7:0]  OFS_EXEC_CNT  = 8'h04;
  localparam logic [1:0]  WIN_IDX       = 2'h1;
  localparam logic [1:0]  WIN_MOD       = 2'h2;
  localparam int          MODE_DUAL     = 0;
  localparam int          MODE_BC_ONE   = 1;
  localparam int          MODE_BC_NINE  = 2;
  localparam logic [2:0]  MODE_RESET    = 3'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

// >>> hw/dmc_idx_bank.sv
// index and modify register bank with registered read ports
// assumes write port 0 has the highest priority when ports collide

`timescale 1ns/1ps

module dmc_idx_bank
  import dmc_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 5,
  parameter int N_RD   = 5,
  parameter int N_WR   = 3
) (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [N_RD*ADDR_W-1:0]   rd_addr,
  output logic      [N_RD*DATA_W-1:0]   rd_data,
  input  wire logic [N_WR-1:0]          wr_en,
  input  wire logic [N_WR*ADDR_W-1:0]   wr_addr,
  input  wire logic [N_WR*DATA_W-1:0]   wr_data
);

  if (N_RD < 1 || N_WR < 1 || ADDR_W < 1 || DATA_W < 1) begin : g_chk
    $error("dmc_idx_bank: bad port or width parameters");
  end

  logic [DATA_W-1:0] mem_reg [2**ADDR_W];

  // ****************************************************************
  // write ports, lower index applied last so it wins
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int e = 0; e < 2**ADDR_W; e++) begin
        mem_reg[e] <= '0;
      end
    end else begin
      for (int w = N_WR - 1; w >= 0; w--) begin
        if (wr_en[w]) begin
          mem_reg[wr_addr[w*ADDR_W +: ADDR_W]] <= wr_data[w*DATA_W +: DATA_W];
        end
      end
    end
  end

  // ****************************************************************
  // read ports, one cycle latency, old data on a same-edge write
  // ****************************************************************
  for (genvar r = 0; r < N_RD; r++) begin : g_rd
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        rd_data[r*DATA_W +: DATA_W] <= '0;
      end else begin
        rd_data[r*DATA_W +: DATA_W] <= mem_reg[rd_addr[r*ADDR_W +: ADDR_W]];
      end
    end
  end

endmodule

// >>> bench/dmc_mem_model.sv
// memory bus side model: counts the transfers each bus accepts
// assumes requests only count while ex_valid is high
`timescale 1ns/1ps
module dmc_mem_model (
  input  wire logic       aclk,
  input  wire logic       ex_valid,
  output logic      [7:0] dm_count,
  output logic      [7:0] pm_count
);
  // ****************************************************************
  // both buses take one transfer per executed instruction
  // ****************************************************************
  initial dm_count = 8'h00;
  initial pm_count = 8'h00;
  always @(posedge aclk) if (ex_valid) begin
    dm_count <= dm_count + 8'h01;
    pm_count <= pm_count + 8'h01;
  end
endmodule

// >>> bench/dmc_exec_tb.sv
// self-checking bench for the compute plus dual move decoder
// assumes the memory model only counts and holds no data
`timescale 1ns/1ps
module dmc_exec_tb;
  import dmc_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, instr_valid = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, dmc, pmc;
  logic [31:0] wdata = 32'h0, rdata, dax, day, pax, pay;
  logic [47:0] instr_word = 48'h0;
  logic [22:0] cmp;
  logic [3:0] ddr, pdr;
  logic [1:0] bresp, rresp;
  logic awr, wr, bv, arr, rv, exv, dual, alu, mul, shf, dw, dsh, pw, psh;
  int failures = 0, samples_checked = 0;
  always #5 aclk = ~aclk;
  dmc_exec i_dmc_exec (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rready), .instr_valid(instr_valid), .instr_word(instr_word),
    .ex_valid(exv), .ex_dual(dual), .ex_alu_go(alu), .ex_mul_go(mul), .ex_shf_go(shf),
    .ex_compute(cmp), .dm_write(dw), .dm_addr_x(dax), .dm_addr_y(day), .dm_dreg(ddr),
    .dm_shared(dsh), .pm_write(pw), .pm_addr_x(pax), .pm_addr_y(pay), .pm_dreg(pdr), .pm_shared(psh));
  dmc_mem_model i_dmc_mem_model (.aclk(aclk), .ex_valid(exv), .dm_count(dmc), .pm_count(pmc));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task complete_run;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // wide enough for the packed groups of outputs compared at once
  task chk(input logic [127:0] seen, input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task hang_if(input logic ok);
    if (ok !== 1'b1) begin
      failures++;
      complete_run();
    end
  endtask
  // waits are bounded; the slave answer time is never assumed
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awv <= 1; wv <= 1; awaddr <= a; wdata <= d;
    n = 0;
    do begin @(posedge aclk); n++; end while (!(awr && wr) && n < 50);
    hang_if(awr && wr);
    awv <= 0; wv <= 0; bready <= 1;
    n = 0;
    do begin @(posedge aclk); n++; end while (!bv && n < 50);
    hang_if(bv);
    bready <= 0;
    // the execution count is read-only, a write there is refused
    chk(bresp, (a == 8'h04) ? RESP_SLVERR : RESP_OKAY);
  endtask
  task rd_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge aclk);
    arv <= 1; araddr <= a;
    n = 0;
    do begin @(posedge aclk); n++; end while (!arr && n < 50);
    hang_if(arr);
    arv <= 0; rready <= 1;
    n = 0;
    do begin @(posedge aclk); n++; end while (!rv && n < 50);
    hang_if(rv);
    rready <= 0;
    chk(rdata, d);
    chk(rresp, r);
  endtask
  function automatic logic [47:0] mk(logic dd, logic [2:0] di, dm, logic pd, logic [3:0] dr,
                                     logic [2:0] pi, pm, logic [3:0] pr, logic [22:0] c);
    return {TYPE_CODE, dd, di, dm, pd, dr, pi, pm, pr, c};
  endfunction
  task put(input logic [47:0] w);
    @(posedge aclk);
    instr_valid <= 1; instr_word <= w;
  endtask
  task fire(input logic [47:0] w);
    put(w);
    @(posedge aclk);
    instr_valid <= 0;
    @(posedge aclk);
    #1;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_single; // back to back post-modify, opposite directions
    wr_reg(8'h40, 32'h100); wr_reg(8'h84, 32'h4); wr_reg(8'h60, 32'h200); wr_reg(8'hA0, 32'h8);
    put(mk(1, 0, 1, 0, 4'h5, 0, 0, 4'h3, 0)); put(mk(1, 0, 1, 0, 4'h5, 0, 0, 4'h3, 0));
    @(posedge aclk); instr_valid <= 0; #1;
    chk({dw, pw, dax}, {2'b10, 32'h100});
    chk({pax, ddr, pdr}, {32'h200, 8'h53});
    @(posedge aclk); #1;
    chk({exv, dax, pax}, {1'b1, 32'h104, 32'h208});
    rd_reg(8'h40, 32'h108, RESP_OKAY);
  endtask
  task t_dual;
    wr_reg(8'h00, 32'h1);
    fire(mk(0, 0, 1, 1, 4'h2, 0, 0, 4'h7, 0));
    chk({dual, dw, pw, dsh, psh}, 5'b10100);
    chk({dax, day}, {32'h108, 32'h109});
    chk({pax, pay, ddr, pdr}, {32'h210, 32'h211, 8'h27});
    rd_reg(8'h40, 32'h10C, RESP_OKAY);
  endtask
  task t_bcast;
    wr_reg(8'h44, 32'h300); wr_reg(8'h64, 32'h400); wr_reg(8'h00, 32'h7);
    fire(mk(0, 1, 0, 0, 4'h4, 1, 0, 4'h6, 0));
    chk({dax, day, dsh}, {32'h300, 32'h300, 1'b1});
    chk({pax, pay, psh}, {32'h400, 32'h400, 1'b1});
    rd_reg(8'h00, 32'h7, RESP_OKAY);
  endtask
  task t_units;
    logic [22:0] c;
    wr_reg(8'h00, 32'h0);
    for (int u = 0; u < 4; u++) begin
      c = {1'b0, 2'(u), 20'h00001};
      fire(mk(0, 0, 0, 0, 4'h0, 0, 0, 4'h0, c));
      chk({cmp, alu, mul, shf}, {c, u == 0, u[0], u == 2});
    end
    fire(mk(0, 0, 0, 0, 4'h0, 0, 0, 4'h0, 0));
    chk({exv, alu, mul, shf}, 4'b1000);
    fire({3'h2, 45'h0});
    chk(exv, 1'b0);
    chk({dmc, pmc}, {8'h09, 8'h09});
    wr_reg(8'h04, 32'h5);
    rd_reg(8'h04, 32'h9, RESP_OKAY);
    rd_reg(8'h08, 32'h0, RESP_SLVERR);
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    t_single();
    t_dual();
    t_bcast();
    t_units();
    complete_run();
  end
endmodule
